// >>> shared/eeprom_sequence_loader_map.svh
// Constants of the EEPROM sequence loader: codes and counts.
// Included by the loader only; definitions only.
`ifndef EEPROM_SEQUENCE_LOADER_MAP_SVH
`define EEPROM_SEQUENCE_LOADER_MAP_SVH
`define CODE_XFER_MAX 8'h7F
`define CODE_COND_BASE 8'hB0
`define CODE_COND_MAX 8'hBF
`define CODE_PAUSE 8'hFE
`define CODE_END 8'hFF
`define ARB_SCL_LIMIT 8'hFF
`define BUF_DEPTH 2'h2
`endif

// >>> shared/eeprom_sequence_loader_pkg.sv
// Types shared by the EEPROM sequence loader and its bench.
// Uses none of the map header's constants; only the loader includes it.
package eeprom_sequence_loader_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_OP = 3'h1,
    S_ADDR_HI = 3'h3,
    S_ADDR_LO = 3'h2,
    S_DATA = 3'h6,
    S_SUM = 3'h7
  } seq_state_e;
  typedef enum logic [1:0] {
    A_IDLE = 2'h0,
    A_WAIT = 2'h1,
    A_OWN = 2'h3
  } arb_state_e;
  typedef enum logic [1:0] {
    K_OP = 2'h0,
    K_ADDR = 2'h1,
    K_DATA = 2'h2,
    K_SUM = 2'h3
  } byte_kind_e;
  typedef struct packed {
    byte_kind_e kind;
    logic [7:0] data;
  } out_word_s;
endpackage : eeprom_sequence_loader_pkg

// >>> logic/eeprom_sequence_loader.sv
// EEPROM sequence loader: instruction walker with conditional
// processing on download, pause on upload, end of data, checksum and I2C bus arbitration.
// Assumes a byte engine that reads or writes the EEPROM, and that
// all inputs, SDA and SCL among them, are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_sequence_loader_map.svh"
module eeprom_sequence_loader (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] condition_id,
  input wire logic start,
  input wire logic upload,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic in_ready,
  output logic out_valid,
  output eeprom_sequence_loader_pkg::out_word_s out_word,
  input wire logic out_ready,
  output logic [15:0] ee_addr,
  output logic busy,
  output logic checksum_error,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_drive_high,
  input wire logic xfer_req,
  input wire logic xfer_done,
  output logic bus_grant,
  output logic arb_lost,
  output logic bus_busy
);
  import eeprom_sequence_loader_pkg::*;

  function automatic logic is_cond(input logic [7:0] b);
    return b >= `CODE_COND_BASE && b <= `CODE_COND_MAX;
  endfunction : is_cond

  function automatic logic [3:0] cond_value(input logic [7:0] b);
    logic [7:0] d;
    d = b - `CODE_COND_BASE;
    return d[3:0];
  endfunction : cond_value

  seq_state_e state, next_state;
  logic is_up, next_is_up;
  logic [15:0] map, next_map;
  logic [15:0] ptr, next_ptr;
  logic [7:0] sum, next_sum;
  logic [7:0] remain, next_remain;
  logic next_checksum_error;
  logic take, skip, emit_ok, sum_bad;
  logic bin_valid, bin_ready;
  out_word_s bin_word;

  assign take = in_valid && in_ready;
  assign sum_bad = in_byte != sum;
  // Skip when the ID is set, the map is not empty and lacks the ID
  assign skip = !is_up && condition_id != 4'h0 && map != 16'h0000
    && !map[condition_id];
  assign emit_ok = is_up || !skip;
  assign busy = state != S_IDLE;
  assign ee_addr = ptr;
  assign in_ready = bin_ready && state != S_IDLE
    && !(state == S_SUM && is_up);

  always_comb begin
    next_state = state;
    next_is_up = is_up;
    next_map = map;
    next_ptr = ptr;
    next_sum = sum;
    next_remain = remain;
    next_checksum_error = checksum_error;
    bin_valid = 1'b0;
    bin_word = '{kind: K_OP, data: in_byte};
    if (take && state != S_SUM) begin
      next_ptr = ptr + 16'h0001;
      next_sum = sum + in_byte;
    end
    case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_OP;
          next_is_up = upload;
          next_map = 16'h0000;
          next_sum = 8'h00;
          if (!upload) begin
            next_checksum_error = 1'b0;
          end
        end
      end
      S_OP: begin
        if (take) begin
          if (in_byte == `CODE_END) begin
            next_state = S_SUM;
            bin_valid = is_up;
          end else if (is_up && in_byte == `CODE_PAUSE) begin
            next_state = S_IDLE;
            next_ptr = ptr;
            next_sum = sum;
          end else if (!is_up && is_cond(in_byte)) begin
            bin_valid = 1'b1;
            if (cond_value(in_byte) == 4'h0) begin
              next_map = 16'h0000;
            end else begin
              next_map = map | (16'h0001 << cond_value(in_byte));
            end
          end else begin
            bin_valid = emit_ok;
            if (in_byte <= `CODE_XFER_MAX) begin
              next_state = S_ADDR_HI;
              next_remain = in_byte;
            end
          end
        end
      end
      S_ADDR_HI: begin
        bin_word.kind = K_ADDR;
        bin_valid = take && emit_ok;
        if (take) begin
          next_state = S_ADDR_LO;
        end
      end
      S_ADDR_LO: begin
        bin_word.kind = K_ADDR;
        bin_valid = take && emit_ok;
        if (take) begin
          next_state = S_DATA;
        end
      end
      S_DATA: begin
        // Skipped payload is still consumed to find the next code
        bin_word.kind = K_DATA;
        bin_valid = take && emit_ok;
        if (take) begin
          next_remain = remain - 8'h01;
          if (remain == 8'h00) begin
            next_state = S_OP;
          end
        end
      end
      S_SUM: begin
        if (is_up) begin
          bin_word = '{kind: K_SUM, data: sum};
          bin_valid = bin_ready;
          if (bin_ready) begin
            next_ptr = 16'h0000;
            next_state = S_IDLE;
          end
        end else if (take) begin
          next_ptr = 16'h0000;
          next_checksum_error = sum_bad;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= S_IDLE;
      is_up <= 1'b0;
      map <= 16'h0000;
      ptr <= 16'h0000;
      sum <= 8'h00;
      remain <= 8'h00;
      checksum_error <= 1'b0;
    end else begin
      state <= next_state;
      is_up <= next_is_up;
      map <= next_map;
      ptr <= next_ptr;
      sum <= next_sum;
      remain <= next_remain;
      checksum_error <= next_checksum_error;
    end
  end

  // Two-entry buffer so a receiver stall loses no word
  out_word_s mem [0:1];
  out_word_s next_mem [0:1];
  logic wp, rp, next_wp, next_rp;
  logic [1:0] cnt, next_cnt;
  logic pop;

  assign bin_ready = cnt != `BUF_DEPTH;
  assign out_valid = cnt != 2'h0;
  assign out_word = mem[rp];
  assign pop = out_valid && out_ready;

  always_comb begin
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (bin_valid) begin
      next_mem[wp] = bin_word;
      next_wp = !wp;
    end
    if (pop) begin
      next_rp = !rp;
    end
    if (bin_valid && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !bin_valid) begin
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else begin
      mem <= next_mem;
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Bus arbitration; same logic serves a dedicated or shared bus
  arb_state_e arb, next_arb;
  logic scl_q, sda_q, force_try, next_force_try, next_bus_busy;
  logic [7:0] timer, next_timer;
  logic start_seen, stop_seen, scl_rise, clash;

  assign start_seen = scl_in && scl_q && sda_q && !sda_in;
  assign stop_seen = scl_in && scl_q && !sda_q && sda_in;
  assign scl_rise = scl_in && !scl_q;
  assign clash = arb == A_OWN && sda_drive_high && scl_in && !sda_in;
  assign bus_grant = arb == A_OWN;

  always_comb begin
    next_arb = arb;
    next_timer = timer;
    next_force_try = force_try;
    next_bus_busy = bus_busy;
    arb_lost = 1'b0;
    if (start_seen) begin
      next_bus_busy = 1'b1;
    end else if (stop_seen) begin
      next_bus_busy = 1'b0;
    end
    case (arb)
      A_IDLE: begin
        if (xfer_req) begin
          next_force_try = 1'b0;
          if ((bus_busy && !force_try) || !scl_in) begin
            next_arb = A_WAIT;
            next_timer = 8'h00;
          end else begin
            next_arb = A_OWN;
          end
        end
      end
      A_WAIT: begin
        if (stop_seen) begin
          next_arb = A_IDLE;
        end else if (scl_rise) begin
          next_timer = timer + 8'h01;
          if (timer == `ARB_SCL_LIMIT - 8'h01) begin
            next_arb = A_IDLE;
            next_force_try = 1'b1;
          end
        end
      end
      A_OWN: begin
        if (clash) begin
          arb_lost = 1'b1;
          next_arb = A_WAIT;
          next_timer = 8'h00;
        end else if (xfer_done) begin
          next_arb = A_IDLE;
        end
      end
      default: begin
        next_arb = A_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      arb <= A_IDLE;
      timer <= 8'h00;
      force_try <= 1'b0;
      bus_busy <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      arb <= next_arb;
      timer <= next_timer;
      force_try <= next_force_try;
      bus_busy <= next_bus_busy;
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  sequence s_pause;
    state == S_OP && is_up && take && in_byte == `CODE_PAUSE;
  endsequence
  sequence s_clash;
    clash;
  endsequence

  property p_pause;
    @(posedge mclk) disable iff (!reset_n)
    s_pause |=> state == S_IDLE && $stable(ptr);
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause did not idle with pointer kept");

  property p_end_up;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_SUM && is_up && bin_ready) |-> bin_valid
      && bin_word.kind == K_SUM ##1 ptr == 16'h0000 && state == S_IDLE;
  endproperty
  a_end_up: assert property (p_end_up)
    else $error("upload end did not write checksum");

  property p_end_down;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_SUM && !is_up && take) |=> ptr == 16'h0000
      && state == S_IDLE && checksum_error == $past(sum_bad);
  endproperty
  a_end_down: assert property (p_end_down)
    else $error("download end check wrong");

  property p_cond_exec;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_OP && !is_up && take && is_cond(in_byte)) |-> bin_valid;
  endproperty
  a_cond_exec: assert property (p_cond_exec)
    else $error("conditional code not executed");

  property p_skip;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_OP && skip && take && !is_cond(in_byte)) |-> !bin_valid;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skipped code was emitted");

  property p_map_acc;
    @(posedge mclk) disable iff (!reset_n)
    (state == S_OP && !is_up && take && in_byte > `CODE_COND_BASE
      && in_byte <= `CODE_COND_MAX) |=> (map & $past(map)) == $past(map)
      && map != 16'h0000;
  endproperty
  a_map_acc: assert property (p_map_acc)
    else $error("condition map lost an entry");

  property p_busy_hold;
    @(posedge mclk) disable iff (!reset_n)
    (arb == A_IDLE && xfer_req && bus_busy && !force_try)
      |=> arb == A_WAIT ##1 !bus_grant;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("granted a busy bus");

  property p_lost;
    @(posedge mclk) disable iff (!reset_n)
    s_clash |-> arb_lost ##1 arb == A_WAIT && timer == 8'h00;
  endproperty
  a_lost: assert property (p_lost)
    else $error("clash did not abort");

  property p_timer;
    @(posedge mclk) disable iff (!reset_n)
    (arb == A_WAIT && scl_rise && !stop_seen && timer == 8'hFE)
      |=> arb == A_IDLE && force_try;
  endproperty
  a_timer: assert property (p_timer)
    else $error("arbitration timer did not force retry");
endmodule : eeprom_sequence_loader
`default_nettype wire

// >>> verification/eeprom_image_source.sv
// Byte source standing in for the EEPROM reader side of the loader.
// Assumes the bench loads image and count, then pulses go.
`timescale 1ns/1ps
`default_nettype none
module eeprom_image_source (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [7:0] image [0:23],
  input wire logic [4:0] count,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_byte
);
  logic [4:0] pos;
  always_ff @(posedge mclk) begin
    if (!reset_n || go) begin
      pos <= 5'h00;
    end else if (in_valid && in_ready) begin
      pos <= pos + 5'h01;
    end
  end
  // A byte is held until taken; outside a valid byte the data line changes
  assign in_valid = !go && (pos < count);
  assign in_byte = in_valid ? image[pos] : {pos, 3'h5};
endmodule : eeprom_image_source
`default_nettype wire

// >>> verification/eeprom_sequence_loader_test.sv
// Self-checking bench of the EEPROM sequence loader.
// Assumes the package, map header and byte source are compiled first.
`timescale 1ns/1ps
`default_nettype none
module eeprom_sequence_loader_test;
  import eeprom_sequence_loader_pkg::*;
  localparam logic [191:0] DL = {160'h00000111B100000222B200000333B000000444FF, 32'h0};
  localparam logic [191:0] UP_END = {40'h00000555FF, 152'h0};
  localparam logic [191:0] UP_PAUSE = {40'h00000555FE, 152'h0};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] condition_id = 4'h0;
  logic start = 1'b0;
  logic upload = 1'b0;
  logic go = 1'b0;
  logic out_ready = 1'b1;
  logic scl_in = 1'b1;
  logic sda_in = 1'b1;
  logic sda_drive_high = 1'b0;
  logic xfer_req = 1'b0;
  logic xfer_done = 1'b0;
  logic in_valid, in_ready, out_valid, busy, checksum_error;
  logic bus_grant, arb_lost, bus_busy;
  logic [7:0] in_byte;
  logic [15:0] ee_addr;
  out_word_s out_word;
  logic [7:0] image [0:23];
  logic [4:0] count = 5'h00;
  logic [31:0] seen;
  logic [7:0] n_ops;
  logic [7:0] sum_word;
  int mismatches = 0;
  int n_compared = 0;

  initial begin
    forever #50 mclk = ~mclk;
  end

  eeprom_sequence_loader DUT (.mclk, .reset_n, .condition_id, .start,
    .upload, .in_valid, .in_byte, .in_ready, .out_valid, .out_word,
    .out_ready, .ee_addr, .busy, .checksum_error, .scl_in, .sda_in,
    .sda_drive_high, .xfer_req, .xfer_done, .bus_grant, .arb_lost,
    .bus_busy);

  eeprom_image_source src (.mclk, .reset_n, .go, .image, .count,
    .in_ready, .in_valid, .in_byte);

  // Collects payload bytes, counts opcode words, keeps the checksum word
  always @(posedge mclk) begin
    if (out_valid && out_ready && out_word.kind == K_OP) begin
      n_ops <= n_ops + 8'h01;
    end
    if (out_valid && out_ready && out_word.kind == K_DATA) begin
      seen <= {seen[23:0], out_word.data};
    end
    if (out_valid && out_ready && out_word.kind == K_SUM) begin
      sum_word <= out_word.data;
    end
  end

  task automatic check(input string what, input logic [31:0] got,
      input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Mode 0 no stored sum, 1 correct sum, 2 corrupted sum
  task automatic run(input logic up, input logic [3:0] id,
      input logic [191:0] lit, input int n, input int mode,
      input logic stall);
    int k;
    logic [7:0] s;
    s = 8'h00;
    for (k = 0; k < 24; k++) begin
      image[k] = lit[191 - 8 * k -: 8];
      if (k < n) s = s + image[k];
    end
    image[n] = s + ((mode == 2) ? 8'h01 : 8'h00);
    seen = 32'h0;
    n_ops = 8'h00;
    @(posedge mclk);
    go <= 1'b1;
    count <= 5'(n + int'(mode != 0));
    start <= 1'b1;
    upload <= up;
    condition_id <= id;
    out_ready <= !stall;
    @(posedge mclk);
    go <= 1'b0;
    start <= 1'b0;
    @(negedge mclk);
    if (stall) begin
      repeat (8) @(negedge mclk);
      check("in_ready", in_ready, 1'b0);
      check("out_valid", out_valid, 1'b1);
      @(posedge mclk);
      out_ready <= 1'b1;
    end
    for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge mclk);
    check("busy", busy, 1'b0);
    repeat (3) @(negedge mclk);
  endtask : run

  task automatic dl_table;
    logic [3:0] ids [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
    logic [31:0] exp [5] = '{32'h11223344, 32'h11223344, 32'h00113344,
      32'h00001144, 32'h00001144};
    logic [7:0] exp_ops [5] = '{8'h07, 8'h07, 8'h06, 8'h05, 8'h05};
    int i;
    for (i = 0; i < 5; i++) begin
      run(1'b0, ids[i], DL, 20, 1, 1'b0);
      check("data", seen, exp[i]);
      check("ops", n_ops, exp_ops[i]);
      check("checksum_error", checksum_error, 1'b0);
      check("ee_addr", ee_addr, 16'h0000);
    end
  endtask : dl_table

  task automatic grant_within(input logic v);
    int k;
    for (k = 0; k < 6 && bus_grant !== v; k++) @(negedge mclk);
    check("bus_grant", bus_grant, v);
  endtask : grant_within

  task automatic pulse_scl;
    @(posedge mclk);
    scl_in <= 1'b0;
    repeat (2) @(posedge mclk);
    scl_in <= 1'b1;
    @(posedge mclk);
  endtask : pulse_scl

  task automatic end_xfer;
    @(posedge mclk);
    xfer_done <= 1'b1;
    xfer_req <= 1'b0;
    @(posedge mclk);
    xfer_done <= 1'b0;
    grant_within(1'b0);
  endtask : end_xfer

  task automatic arb_test;
    int k;
    @(posedge mclk);
    xfer_req <= 1'b1;
    grant_within(1'b1);
    @(posedge mclk);
    sda_drive_high <= 1'b1;
    sda_in <= 1'b0;
    @(negedge mclk);
    check("arb_lost", arb_lost, 1'b1);
    @(posedge mclk);
    sda_drive_high <= 1'b0;
    repeat (3) @(negedge mclk);
    check("bus_grant", bus_grant, 1'b0);
    check("bus_busy", bus_busy, 1'b1);
    for (k = 0; k < 254; k++) pulse_scl();
    check("bus_grant", bus_grant, 1'b0);
    pulse_scl();
    grant_within(1'b1);
    end_xfer();
    @(posedge mclk);
    sda_in <= 1'b1;
    repeat (3) @(negedge mclk);
    check("bus_busy", bus_busy, 1'b0);
    @(posedge mclk);
    scl_in <= 1'b0;
    sda_in <= 1'b0;
    xfer_req <= 1'b1;
    repeat (5) @(negedge mclk);
    check("bus_grant", bus_grant, 1'b0);
    @(posedge mclk);
    scl_in <= 1'b1;
    // The other master ends its transaction with a stop
    @(posedge mclk);
    sda_in <= 1'b1;
    grant_within(1'b1);
    end_xfer();
    @(posedge mclk);
    sda_in <= 1'b0;
    repeat (3) @(negedge mclk);
    @(posedge mclk);
    xfer_req <= 1'b1;
    repeat (5) @(negedge mclk);
    check("bus_grant", bus_grant, 1'b0);
    @(posedge mclk);
    sda_in <= 1'b1;
    grant_within(1'b1);
    end_xfer();
  endtask : arb_test

  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    check("ee_addr", ee_addr, 16'h0000);
    run(1'b0, 4'h0, DL, 20, 2, 1'b1);
    check("checksum_error", checksum_error, 1'b1);
    dl_table();
    run(1'b1, 4'h2, UP_END, 5, 0, 1'b1);
    check("sum_word", sum_word, 8'h59);
    check("ee_addr", ee_addr, 16'h0000);
    run(1'b1, 4'h0, UP_PAUSE, 5, 0, 1'b0);
    check("ee_addr", ee_addr, 16'h0004);
    arb_test();
    final_report();
  end

  initial begin
    #3000000;
    mismatches++;
    final_report();
  end
endmodule : eeprom_sequence_loader_test
`default_nettype wire
